// ===== testbench/macsy_monitor.sv
`include "macsy_defines.svh"
`default_nettype none
module macsy_monitor #(
  parameter int W = 32
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic [11:0]  s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [31:0]  s_axi_wdata,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic         can_sync_strobe,
  input wire logic         sync_input_terminal,
  input wire logic [W-1:0] analog_input_a,
  input wire logic [W-1:0] phase_input,
  input wire logic [W-1:0] analog_input_b,
  input wire logic         lock_status,
  input wire logic         cycle_start,
  input wire logic [W-1:0] interp_output_a,
  input wire logic [W-1:0] interp_phase_output,
  input wire logic [W-1:0] interp_output_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [1:0]  mode_q;
  logic [2:0]  edge_cnt;
  logic        can_q;
  logic        term_q;
  logic        quiet;
  // shadow of the mode register; only accepted writes count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q   <= 2'h0;
      edge_cnt <= 3'h0;
      can_q    <= 1'b0;
      term_q   <= 1'b0;
    end else begin
      can_q  <= can_sync_strobe;
      term_q <= sync_input_terminal;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == `MACSY_RESP_OKAY
          && aw_q == `MACSY_A_MODE) mode_q <= w_q[1:0];
      if (((can_sync_strobe && !can_q) || (sync_input_terminal && !term_q))
          && edge_cnt != 3'h7) edge_cnt <= edge_cnt + 3'h1;
    end
  end
  // mode may differ from the shadow while a write response is pending
  assign quiet = !s_axi_bvalid;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence can_edge_s;
    mode_q == 2'h1 && quiet && can_sync_strobe && !can_q;
  endsequence
  sequence term_edge_s;
    mode_q == 2'h2 && quiet && sync_input_terminal && !term_q;
  endsequence
  sequence start_s;
    cycle_start ##1 !cycle_start;
  endsequence
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_ready_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
  a_pass_thru: assert property (mode_q == 2'h0 && quiet |=>
    interp_output_a == $past(analog_input_a)
    && interp_phase_output == $past(phase_input)
    && interp_output_b == $past(analog_input_b)) else $error("no pass");
  a_pass_idle: assert property (mode_q == 2'h0 && quiet |->
    !cycle_start && !lock_status) else $error("sync active in mode 0");
  a_can_start: assert property (can_edge_s |-> ##[1:2] start_s)
    else $error("no cycle start after telegram");
  a_term_start: assert property (term_edge_s |-> ##[2:5] start_s)
    else $error("no cycle start after pin edge");
  a_lock_late: assert property (lock_status |-> edge_cnt >= 3'h6)
    else $error("lock before enough edges");
endmodule : macsy_monitor
bind macsy_top macsy_monitor #(.W(W)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .can_sync_strobe(can_sync_strobe),
  .sync_input_terminal(sync_input_terminal),
  .analog_input_a(analog_input_a), .phase_input(phase_input),
  .analog_input_b(analog_input_b), .lock_status(lock_status),
  .cycle_start(cycle_start), .interp_output_a(interp_output_a),
  .interp_phase_output(interp_phase_output),
  .interp_output_b(interp_output_b)
);
`default_nettype wire

// ===== testbench/macsy_sync_master.sv
`default_nettype none
module macsy_sync_master (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic        use_term,
  input  wire logic [19:0] period,
  output logic             can_sync_strobe,
  output logic             sync_input_terminal
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] cnt_reg;
  logic [19:0] cnt_next;
  logic        can_next;
  logic        term_next;
  always_comb begin
    cnt_next  = (cnt_reg == period - 20'h1) ? 20'h0 : cnt_reg + 20'h1;
    can_next  = !use_term && cnt_reg < 20'h4;
    term_next = use_term && cnt_reg < 20'h4;
  end
  // idle lines are driven low, as the terminal is between pulses
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_reg             <= 20'h0;
      can_sync_strobe     <= 1'b0;
      sync_input_terminal <= 1'b0;
    end else begin
      cnt_reg             <= cnt_next;
      can_sync_strobe     <= can_next;
      sync_input_terminal <= term_next;
    end
  end
endmodule : macsy_sync_master
`default_nettype wire

// ===== testbench/macsy_top_tb.sv
`include "macsy_defines.svh"
`default_nettype none
module macsy_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import macsy_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic        can_sync_strobe, sync_input_terminal, lock_status, cycle_start;
  logic [31:0] analog_input_a = 32'h0, phase_input = 32'h0;
  logic [31:0] analog_input_b = 32'h0;
  logic [31:0] interp_output_a, interp_phase_output, interp_output_b;
  logic        run = 1'b0, use_term = 1'b0;
  logic [19:0] period = 20'd1000;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  always #2 aclk = ~aclk;
  macsy_top #(.W(32)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .can_sync_strobe(can_sync_strobe),
    .sync_input_terminal(sync_input_terminal),
    .analog_input_a(analog_input_a), .phase_input(phase_input),
    .analog_input_b(analog_input_b), .lock_status(lock_status),
    .cycle_start(cycle_start), .interp_output_a(interp_output_a),
    .interp_phase_output(interp_phase_output),
    .interp_output_b(interp_output_b));
  macsy_sync_master u_master (.aclk(aclk), .aresetn(aresetn), .run(run),
    .use_term(use_term), .period(period), .can_sync_strobe(can_sync_strobe),
    .sync_input_terminal(sync_input_terminal));
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit aw_done, w_done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 7; i++) begin
      axi_rd(12'(i * 4), d, r);
      chk(d, (i == 1 || i == 2 || i == 5) ? 32'h1 : 32'h0);
    end
    axi_rd(12'h020, d, r);
    chk({30'h0, r}, {30'h0, `MACSY_RESP_SLVERR});
    chk(d, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_range();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(`MACSY_A_SYNC_CYC, 32'h0, r);
    chk({30'h0, r}, {30'h0, `MACSY_RESP_SLVERR});
    axi_wr(`MACSY_A_SYNC_CYC, 32'hE, r);
    chk({30'h0, r}, {30'h0, `MACSY_RESP_SLVERR});
    axi_wr(`MACSY_A_INTERP_CYC, 32'hE, r);
    chk({30'h0, r}, {30'h0, `MACSY_RESP_SLVERR});
    axi_wr(`MACSY_A_SYNC_CYC, 32'hD, r);
    chk({30'h0, r}, {30'h0, `MACSY_RESP_OKAY});
    axi_rd(`MACSY_A_SYNC_CYC, d, r);
    chk(d, 32'hD);
    axi_wr(`MACSY_A_MODE, 32'h3, r);
    chk({30'h0, r}, {30'h0, `MACSY_RESP_SLVERR});
    $display("test range done");
  endtask : t_range
  task automatic t_pass(input logic [31:0] base);
    logic [1:0] r;
    axi_wr(`MACSY_A_MODE, {30'h0, MACSY_MODE_PASS}, r);
    analog_input_a <= base;
    phase_input <= base + 32'h1;
    analog_input_b <= base + 32'h2;
    repeat (3) @(posedge aclk);
    chk(interp_output_a, base);
    chk(interp_phase_output, base + 32'h1);
    chk(interp_output_b, base + 32'h2);
    chk({31'h0, lock_status}, 32'h0);
    $display("test pass done");
  endtask : t_pass
  // counts master edges and cycle starts over 3520 cycles, stopping the master after 3500
  task automatic run_sync(input logic term, output int edges,
                          output int starts);
    logic prev, now;
    edges = 0;
    starts = 0;
    prev = 1'b0;
    @(posedge aclk);
    use_term <= term;
    run <= 1'b1;
    for (int i = 0; i < 3520; i++) begin
      @(posedge aclk);
      now = term ? sync_input_terminal : can_sync_strobe;
      if (now && !prev) edges++;
      prev = now;
      if (cycle_start === 1'b1) starts++;
      if (i == 3500) run <= 1'b0;
    end
  endtask : run_sync
  task automatic t_can();
    logic [31:0] d;
    logic [1:0]  r;
    int          e, s;
    axi_wr(`MACSY_A_MODE, {30'h0, MACSY_MODE_CAN}, r);
    run_sync(1'b0, e, s);
    chk(32'(s), 32'(e));
    axi_rd(`MACSY_A_PERIOD, d, r);
    chk(d, 32'd1000);
    chk({31'h0, lock_status}, 32'h0);
    $display("test can done");
  endtask : t_can
  task automatic t_term();
    logic [31:0] d;
    logic [1:0]  r;
    int          e, s;
    axi_wr(`MACSY_A_MODE, {30'h0, MACSY_MODE_TERM}, r);
    period <= 20'd800;
    run_sync(1'b1, e, s);
    chk(32'(s), 32'(e));
    axi_rd(`MACSY_A_PERIOD, d, r);
    chk(d, 32'd800);
    chk({31'h0, lock_status}, 32'h0);
    $display("test term done");
  endtask : t_term
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_range();
    t_pass(32'h1000_0000);
    t_can();
    t_term();
    t_pass(32'h8000_0001);
    finish_test();
  end
endmodule : macsy_top_tb
`default_nettype wire

// ===== verilog/macsy_defines.svh
`ifndef MACSY_DEFINES_SVH
`define MACSY_DEFINES_SVH
`define MACSY_CLK_MHZ        250
`define MACSY_MS_CYCLES      (1000 * `MACSY_CLK_MHZ)
`define MACSY_US_CYCLES      (`MACSY_CLK_MHZ)
`define MACSY_MS_MIN         4'd1
`define MACSY_MS_MAX         4'd13
`define MACSY_WIN_MAX_US     1000
`define MACSY_SHIFT_MAX_US   1000
`define MACSY_LOCK_COUNT     3'd4
`define MACSY_A_MODE         12'h000
`define MACSY_A_SYNC_CYC     12'h004
`define MACSY_A_INTERP_CYC   12'h008
`define MACSY_A_SHIFT        12'h00C
`define MACSY_A_WINDOW       12'h010
`define MACSY_A_CORR         12'h014
`define MACSY_A_STATUS       12'h018
`define MACSY_A_PERIOD       12'h01C
`define MACSY_MODE_RST       2'd0
`define MACSY_CYC_RST        4'd1
`define MACSY_CORR_RST       3'd1
`define MACSY_RESP_OKAY      2'b00
`define MACSY_RESP_SLVERR    2'b10
`endif

// ===== verilog/macsy_interp.sv
`include "macsy_defines.svh"
`default_nettype none
// one linear ramp channel; step = (target - start) / steps
module macsy_interp #(
  parameter int W = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         bypass,
  input  wire logic         restart,
  input  wire logic         step,
  input  wire logic [3:0]   steps,
  input  wire logic [W-1:0] in_value,
  output logic      [W-1:0] out_value
);
  logic signed [W:0]  inc_reg, inc_next;
  logic        [W-1:0] out_reg, out_next;
  logic        [W-1:0] tgt_reg, tgt_next;
  logic        [3:0]   left_reg, left_next;
  logic signed [W:0]  diff;

  always_comb begin
    diff = $signed({in_value[W-1], in_value}) - $signed({out_reg[W-1], out_reg});
    out_next = out_reg;
    inc_next = inc_reg;
    tgt_next = tgt_reg;
    left_next = left_reg;
    if (bypass) begin
      out_next = in_value;
      tgt_next = in_value;
      left_next = 4'd0;
    end else if (restart) begin // RULE13
      tgt_next = in_value;
      inc_next = diff / $signed({1'b0, steps});
      left_next = steps;
    end else if (step && left_reg != 4'd0) begin // RULE21
      left_next = left_reg - 4'd1;
      if (left_reg == 4'd1)
        out_next = tgt_reg;
      else
        out_next = W'(out_reg + inc_reg[W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= '0;
      inc_reg <= '0;
      tgt_reg <= '0;
      left_reg <= 4'd0;
    end else begin
      out_reg <= out_next;
      inc_reg <= inc_next;
      tgt_reg <= tgt_next;
      left_reg <= left_next;
    end
  end
  assign out_value = out_reg;
endmodule : macsy_interp
`default_nettype wire

// ===== verilog/macsy_pkg.sv
`default_nettype none
package macsy_pkg;
  typedef enum logic [1:0] {
    MACSY_MODE_PASS = 2'd0,
    MACSY_MODE_CAN  = 2'd1,
    MACSY_MODE_TERM = 2'd2
  } macsy_mode_t;
  typedef enum logic [2:0] {
    MACSY_S_IDLE = 3'b001,
    MACSY_S_ACQ  = 3'b010,
    MACSY_S_LOCK = 3'b100
  } macsy_state_t;
endpackage : macsy_pkg
`default_nettype wire

// ===== verilog/macsy_top.sv
// How it works
// (RULE1) mode 0: inputs go straight to outputs, no sync.
// (RULE2) mode 1: control cycle follows CAN sync telegram strobe.
// (RULE3) mode 2: control cycle follows sync terminal pulses.
// (RULE4) lock status rises once sync is achieved.
// (RULE5) lock status falls when sync is lost or abandoned.
// (RULE6) period between rising sync edges measured, compared to cycle time.
// (RULE7) cycle time accepted only as whole ms 1 to 13.
// (RULE8) CAN mode: measured telegram period readable by software.
// (RULE9) software sets cycle time below measured CAN period.
// (RULE10) terminal mode: cycle time not below master pulse period.
// (RULE11) master sends sync events with fixed period.
// (RULE12) three inputs interpolated onto outputs between sync events.
// (RULE13) each sync edge restarts interpolation.
// (RULE14) CAN mode: steps derived from sync cycle time.
// (RULE15) terminal mode: interpolation cycle from its own setting.
// (RULE16) CAN mode: bus carries sync strobe and process values.
// (RULE17) terminal mode: sync on terminal, values on separate inputs.
// (RULE18) after reset, several good periods needed before lock.
// (RULE19) terminal mode: lock only with edges inside tolerance window.
// (RULE20) terminal mode: phase offset between edge and cycle start; code delays only for positive offsets, negative ones give no delay.
// (RULE21) interpolation linear, equal increments toward new value.
// (RULE22) terminal input double-synchronised, one edge per pulse.
`include "macsy_defines.svh"
`default_nettype none
module macsy_top
  import macsy_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         can_sync_strobe,
  input  wire logic         sync_input_terminal,
  input  wire logic [W-1:0] analog_input_a,
  input  wire logic [W-1:0] phase_input,
  input  wire logic [W-1:0] analog_input_b,
  output logic              lock_status,
  output logic              cycle_start,
  output logic [W-1:0]      interp_output_a,
  output logic [W-1:0]      interp_phase_output,
  output logic [W-1:0]      interp_output_b
);
  import macsy_pkg::*;

  localparam int MSC = `MACSY_MS_CYCLES;
  localparam int USC = `MACSY_US_CYCLES;

  // ---- register file
  logic [1:0]  mode_reg, mode_next;
  logic [3:0]  sync_cyc_reg, sync_cyc_next;
  logic [3:0]  icyc_reg, icyc_next;
  logic signed [11:0] shift_reg, shift_next;
  logic [10:0] win_reg, win_next;
  logic [2:0]  corr_reg, corr_next;
  logic        aw_reg, aw_next, w_reg, w_next;
  logic [11:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic        bv_reg, bv_next, rv_reg, rv_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  logic [31:0] rd_reg, rd_next;
  logic [23:0] period_reg;
  logic [31:0] wval;
  logic        wr_ok;

  always_comb begin
    mode_next = mode_reg;
    sync_cyc_next = sync_cyc_reg;
    icyc_next = icyc_reg;
    shift_next = shift_reg;
    win_next = win_reg;
    corr_next = corr_reg;
    aw_next = aw_reg;
    w_next = w_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rr_next = rr_reg;
    rd_next = rd_reg;
    wval = wd_reg;
    wr_ok = 1'b1;
    if (s_axi_awvalid && !aw_reg && !bv_reg) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg && !bv_reg) begin
      w_next = 1'b1;
      // partial strobes are treated as full-word writes of masked bytes
      wd_next = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end
    if (aw_reg && w_reg) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bv_next = 1'b1;
      case (awa_reg)
        `MACSY_A_MODE:
          if (wval <= 32'h0000_0002) mode_next = wval[1:0];
          else wr_ok = 1'b0;
        `MACSY_A_SYNC_CYC, `MACSY_A_INTERP_CYC:
          if (wval >= {28'h000_0000, `MACSY_MS_MIN} &&
              wval <= {28'h000_0000, `MACSY_MS_MAX}) begin // RULE7
            if (awa_reg == `MACSY_A_SYNC_CYC) sync_cyc_next = wval[3:0];
            else icyc_next = wval[3:0];
          end else wr_ok = 1'b0;
        `MACSY_A_SHIFT:
          if ($signed(wval) >= -`MACSY_SHIFT_MAX_US &&
              $signed(wval) <= `MACSY_SHIFT_MAX_US)
            shift_next = wval[11:0];
          else wr_ok = 1'b0;
        `MACSY_A_WINDOW:
          if (wval <= 32'(`MACSY_WIN_MAX_US)) win_next = wval[10:0];
          else wr_ok = 1'b0;
        `MACSY_A_CORR:
          if (wval >= 32'h0000_0001 && wval <= 32'h0000_0005)
            corr_next = wval[2:0];
          else wr_ok = 1'b0;
        default: wr_ok = 1'b0;
      endcase
      br_next = wr_ok ? `MACSY_RESP_OKAY : `MACSY_RESP_SLVERR;
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = `MACSY_RESP_OKAY;
      case (s_axi_araddr)
        `MACSY_A_MODE:       rd_next = {30'h0, mode_reg};
        `MACSY_A_SYNC_CYC:   rd_next = {28'h0, sync_cyc_reg};
        `MACSY_A_INTERP_CYC: rd_next = {28'h0, icyc_reg};
        `MACSY_A_SHIFT:      rd_next = {{20{shift_reg[11]}}, shift_reg};
        `MACSY_A_WINDOW:     rd_next = {21'h0, win_reg};
        `MACSY_A_CORR:       rd_next = {29'h0, corr_reg};
        `MACSY_A_STATUS:     rd_next = {31'h0, lock_status};
        `MACSY_A_PERIOD:     rd_next = {8'h0, period_reg}; // RULE8
        default: begin
          rd_next = 32'h0000_0000;
          rr_next = `MACSY_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `MACSY_MODE_RST;
      sync_cyc_reg <= `MACSY_CYC_RST;
      icyc_reg <= `MACSY_CYC_RST;
      shift_reg <= 12'h000;
      win_reg <= 11'h000;
      corr_reg <= `MACSY_CORR_RST;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awa_reg <= 12'h000;
      wd_reg <= 32'h0000_0000;
      bv_reg <= 1'b0;
      br_reg <= 2'b00;
      rv_reg <= 1'b0;
      rr_reg <= 2'b00;
      rd_reg <= 32'h0000_0000;
    end else begin
      mode_reg <= mode_next;
      sync_cyc_reg <= sync_cyc_next;
      icyc_reg <= icyc_next;
      shift_reg <= shift_next;
      win_reg <= win_next;
      corr_reg <= corr_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rr_reg <= rr_next;
      rd_reg <= rd_next;
    end
  end
  // readies taken from next state so each port is a flop
  always_ff @(posedge aclk) begin
    s_axi_awready <= aresetn && !aw_next && !bv_next;
    s_axi_wready  <= aresetn && !w_next && !bv_next;
    s_axi_arready <= aresetn && !rv_next;
  end
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;

  // ---- sync edge capture and period check
  logic [2:0]  term_sync;
  logic        can_d;
  logic        edge_raw;
  macsy_state_t st_reg, st_next;
  logic [23:0] cnt_reg, cnt_next, period_next;
  logic [2:0]  good_reg, good_next;
  logic [23:0] nominal, tol, lo, hi;
  logic [12:0] delay_reg, delay_next;
  logic        pend_reg, pend_next;
  logic [17:0] us_reg, us_next;
  logic        lock_next, cs_next, cs_reg;
  logic        ms_tick;
  logic [3:0]  steps;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_sync <= 3'b000;
      can_d <= 1'b0;
    end else begin
      term_sync <= {term_sync[1:0], sync_input_terminal}; // RULE22
      can_d <= can_sync_strobe;
    end
  end

  always_comb begin
    case (mode_reg)
      MACSY_MODE_CAN:  edge_raw = can_sync_strobe && !can_d; // RULE2 RULE16
      MACSY_MODE_TERM: edge_raw = term_sync[1] && !term_sync[2]; // RULE3 RULE17
      default:         edge_raw = 1'b0;
    endcase
    nominal = 24'(sync_cyc_reg * MSC);
    // CAN mode uses a fixed quarter-ms tolerance since the window is unused
    tol = (mode_reg == MACSY_MODE_TERM) ? 24'(win_reg * USC)
                                        : 24'(MSC / 4);
    lo = nominal - tol;
    hi = nominal + tol;
    st_next = st_reg;
    cnt_next = (cnt_reg == 24'hFF_FFFF) ? cnt_reg : cnt_reg + 24'd1;
    period_next = period_reg;
    good_next = good_reg;
    lock_next = lock_status;
    if (mode_reg == MACSY_MODE_PASS) begin // RULE1
      st_next = MACSY_S_IDLE;
      good_next = 3'd0;
      lock_next = 1'b0;
    end else begin
      case (st_reg)
        MACSY_S_IDLE:
          if (edge_raw) begin
            st_next = MACSY_S_ACQ;
            cnt_next = 24'd0;
          end
        MACSY_S_ACQ, MACSY_S_LOCK: begin
          if (edge_raw) begin
            cnt_next = 24'd0;
            period_next = cnt_reg + 24'd1; // RULE6
            if (cnt_reg + 24'd1 >= lo && cnt_reg + 24'd1 <= hi) begin // RULE19
              if (good_reg == `MACSY_LOCK_COUNT) begin // RULE18
                st_next = MACSY_S_LOCK;
                lock_next = 1'b1; // RULE4
              end else begin
                good_next = good_reg + 3'd1;
              end
            end else begin
              good_next = 3'd0;
              st_next = MACSY_S_ACQ;
              lock_next = 1'b0; // RULE5
            end
          end else if (cnt_reg > hi) begin
            good_next = 3'd0;
            st_next = MACSY_S_IDLE;
            lock_next = 1'b0; // RULE5
          end
        end
        default: st_next = MACSY_S_IDLE;
      endcase
    end
    // control cycle start, delayed by a positive phase offset in terminal mode
    pend_next = pend_reg;
    delay_next = delay_reg;
    cs_next = 1'b0;
    if (edge_raw) begin
      if (mode_reg == MACSY_MODE_TERM && !shift_reg[11] &&
          shift_reg != 12'h000) begin // RULE20
        pend_next = 1'b1;
        delay_next = 13'(shift_reg);
      end else begin
        cs_next = 1'b1;
      end
    end else if (pend_reg && us_reg == 18'd0) begin
      if (delay_reg <= 13'd1) begin
        pend_next = 1'b0;
        cs_next = 1'b1;
      end else begin
        delay_next = delay_reg - 13'd1;
      end
    end
    us_next = (us_reg == 18'(USC - 1) || edge_raw) ? 18'd0 : us_reg + 18'd1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= MACSY_S_IDLE;
      cnt_reg <= 24'd0;
      period_reg <= 24'd0;
      good_reg <= 3'd0;
      lock_status <= 1'b0;
      pend_reg <= 1'b0;
      delay_reg <= 13'd0;
      us_reg <= 18'd0;
      cs_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      period_reg <= period_next;
      good_reg <= good_next;
      lock_status <= lock_next;
      pend_reg <= pend_next;
      delay_reg <= delay_next;
      us_reg <= us_next;
      cs_reg <= cs_next;
    end
  end
  assign cycle_start = cs_reg;

  // ---- interpolation step timing: 1 ms ticks from cycle start
  logic [17:0] ms_reg, ms_next;
  always_comb begin
    ms_next = (cs_reg || ms_reg == 18'(MSC - 1)) ? 18'd0 : ms_reg + 18'd1;
    ms_tick = (ms_reg == 18'(MSC - 1));
    // CAN: one step per ms of sync cycle; terminal: sync/interp ratio
    if (mode_reg == MACSY_MODE_CAN)
      steps = sync_cyc_reg; // RULE14
    else
      steps = (icyc_reg > sync_cyc_reg) ? 4'd1
            : 4'(sync_cyc_reg / icyc_reg); // RULE15
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ms_reg <= 18'd0;
    else ms_reg <= ms_next;
  end

  logic [W-1:0] ins  [3];
  logic [W-1:0] outs [3];
  assign ins[0] = analog_input_a;
  assign ins[1] = phase_input;
  assign ins[2] = analog_input_b;
  for (genvar i = 0; i < 3; i++) begin : g_ch
    macsy_interp #(.W(W)) u_ch ( // RULE12
      .aclk      (aclk),
      .aresetn   (aresetn),
      .bypass    (mode_reg == MACSY_MODE_PASS),
      .restart   (cs_reg),
      .step      (ms_tick),
      .steps     (steps),
      .in_value  (ins[i]),
      .out_value (outs[i])
    );
  end
  assign interp_output_a     = outs[0];
  assign interp_phase_output = outs[1];
  assign interp_output_b     = outs[2];
endmodule : macsy_top
`default_nettype wire
